// >>> acs_defines.svh
`ifndef ACS_DEFINES_SVH
`define ACS_DEFINES_SVH

// Field positions inside the upper nibble of converter_control_reg
`define ACS_CONV_SEL_MSB 3
`define ACS_CONV_SEL_LSB 2
`define ACS_SAMP_SEL_MSB 1
`define ACS_SAMP_SEL_LSB 0

// conv_clock_select codes
`define ACS_CONV_SEL_24 2'h0
`define ACS_CONV_SEL_RSV 2'h1
`define ACS_CONV_SEL_96 2'h2
`define ACS_CONV_SEL_48 2'h3

// conversion_clock_period lengths in cpu_half_period units
`define ACS_TCC_LEN_24 7'h18
`define ACS_TCC_LEN_48 7'h30
`define ACS_TCC_LEN_96 7'h60

// Sample phase lasts two sample clock periods
`define ACS_SAMPLE_PERIODS 5'h2

// Conversion phase step counts
`define ACS_DECISION_STEPS 5'h0A
`define ACS_EQUALIZE_STEPS 5'h04
`define ACS_CONV_STEPS 5'h0E

// Result register load time in cpu_half_period units
`define ACS_LOAD_HALF_PERIODS 5'h04

// First trial word of the approximation
`define ACS_TRIAL_INIT 10'h200

`endif

// >>> acs_pkg.sv
`default_nettype none
package acs_pkg;

  // Sequencer phases
  typedef enum logic [1:0] {
    st_idle,
    st_sample,
    st_convert,
    st_load
  } acs_state_t;

endpackage : acs_pkg
`default_nettype wire

// >>> acs_tmr_if.sv
`timescale 1ns/1ps
`default_nettype none
// Link between sequencer and conversion clock timer
interface acs_tmr_if;
  logic       ce;
  logic       start;
  logic       stop;
  logic [6:0] len;
  logic       expire;

  modport ctl (output ce, output start, output stop, output len, input expire);
  modport tmr (input ce, input start, input stop, input len, output expire);
endinterface : acs_tmr_if
`default_nettype wire

// >>> acs_period_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "acs_defines.svh"
module acs_period_timer import acs_pkg::*; (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Control link
  acs_tmr_if.tmr   t
);

  logic [6:0] cnt_ff;
  logic       run_ff;

  // One expire per conversion_clock_period, counted in half-periods
  assign t.expire = t.ce & run_ff & (cnt_ff == 7'h00);

  ////////////////////////////////////////////////////////////////////////////
  // Down counter reloads itself so periods follow back to back
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_ff <= 7'h00;
      run_ff <= 1'b0;
    end else if (t.ce) begin
      if (t.start) begin
        cnt_ff <= t.len - 7'h01;
        run_ff <= 1'b1;
      end else if (t.stop) begin
        run_ff <= 1'b0;
      end else if (run_ff) begin
        cnt_ff <= (cnt_ff == 7'h00) ? t.len - 7'h01 : cnt_ff - 7'h01;
      end
    end
  end

  a_expire_reload: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    t.expire && !t.stop |=> cnt_ff == $past(t.len) - 7'h01)
    else $error("timer did not reload period length");

endmodule : acs_period_timer
`default_nettype wire

// >>> acs_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "acs_defines.svh"
// Contract
// - A conversion starts with a sample phase before any bit decision.
// - Ten decision steps, one per result bit, one conversion clock each.
// - Four further conversion clocks equalize; fourteen in the conversion phase.
// - Both selects come from the upper four control register bits.
// - Conversion clock: code 00=24, 10=96, 11=48 half-periods; 01 reserved.
// - Sample clock is conversion clock times 1, 2, 4 or 8.
// - Total: 14 conversion clocks, 2 sample clocks, 4 half-periods for load.
// - All durations are counted in CPU half-periods.
module acs_sequencer import acs_pkg::*; (
  // Clock, reset, enable
  input  wire logic       i_clock,
  input  wire logic       i_rst_n,
  input  wire logic       i_clk_en,
  // Control
  input  wire logic       i_start,
  input  wire logic [3:0] i_converter_control_reg_hi,
  // Analog comparator, asynchronous
  input  wire logic       i_cmp_above,
  // Status and result
  output logic            o_busy,
  output logic            o_sampling,
  output logic            o_equalizing,
  output logic            o_result_loading,
  output logic            o_step_strobe,
  output logic [3:0]      o_bit_index,
  output logic [9:0]      o_trial,
  output logic [9:0]      o_result,
  output logic            o_done
);

  acs_tmr_if tmr ();

  acs_state_t state_ff, nxt_state;
  logic [4:0] phase_ff, nxt_phase;
  logic [1:0] conv_sel_ff, samp_sel_ff;
  logic [6:0] tcc_len_ff;
  logic [4:0] samp_periods;
  logic [3:0] bit_idx;
  logic       decide;
  logic       enter_conv;
  logic       finish;
  logic [9:0] trial_ff, nxt_trial;
  logic       cmp_meta_ff, cmp_sync_ff;
  logic       busy_ff, sampling_ff, equalizing_ff, loading_ff, strobe_ff, done_ff;
  logic [3:0] bit_index_ff;
  logic [9:0] result_ff;

  // Conversion clock length from a select code; reserved code falls back to fastest
  function automatic logic [6:0] tcc_len(input logic [1:0] sel);
    case (sel)
      `ACS_CONV_SEL_96: tcc_len = `ACS_TCC_LEN_96;
      `ACS_CONV_SEL_48: tcc_len = `ACS_TCC_LEN_48;
      default:          tcc_len = `ACS_TCC_LEN_24;
    endcase
  endfunction : tcc_len

  ////////////////////////////////////////////////////////////////////////////
  // Timer link; idle uses live fields so the first period is right at start
  assign tmr.ce  = i_clk_en;
  assign tmr.len = (state_ff == st_idle) ?
                   tcc_len(i_converter_control_reg_hi[`ACS_CONV_SEL_MSB:`ACS_CONV_SEL_LSB]) :
                   tcc_len_ff;
  acs_period_timer u_timer (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .t       (tmr.tmr)
  );

  // Sample phase length in conversion clocks: two sample clocks
  assign samp_periods = `ACS_SAMPLE_PERIODS << samp_sel_ff;
  assign bit_idx      = 4'h9 - phase_ff[3:0];
  assign decide       = (state_ff == st_convert) && tmr.expire &&
                        (phase_ff < `ACS_DECISION_STEPS);
  assign enter_conv   = (state_ff == st_sample) && (nxt_state == st_convert);
  assign finish       = i_clk_en && (state_ff == st_load) && (nxt_state == st_idle);

  ////////////////////////////////////////////////////////////////////////////
  // Phase sequencing
  always_comb begin
    nxt_state = state_ff;
    nxt_phase = phase_ff;
    tmr.start = 1'b0;
    tmr.stop  = 1'b0;
    case (state_ff)
      st_idle: begin
        if (i_start) begin
          nxt_state = st_sample;
          nxt_phase = 5'h00;
          tmr.start = 1'b1;
        end
      end
      st_sample: begin
        if (tmr.expire) begin
          if (phase_ff == samp_periods - 5'h01) begin
            nxt_state = st_convert;
            nxt_phase = 5'h00;
          end else begin
            nxt_phase = phase_ff + 5'h01;
          end
        end
      end
      st_convert: begin
        if (tmr.expire) begin
          if (phase_ff == `ACS_CONV_STEPS - 5'h01) begin
            nxt_state = st_load;
            nxt_phase = 5'h00;
            tmr.stop  = 1'b1;
          end else begin
            nxt_phase = phase_ff + 5'h01;
          end
        end
      end
      st_load: begin
        // Load counts raw half-periods, not conversion clocks
        if (phase_ff == `ACS_LOAD_HALF_PERIODS - 5'h01) begin
          nxt_state = st_idle;
          nxt_phase = 5'h00;
        end else begin
          nxt_phase = phase_ff + 5'h01;
        end
      end
      default: begin
        nxt_state = st_idle;
        nxt_phase = 5'h00;
      end
    endcase
  end

  // State registers
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff <= st_idle;
      phase_ff <= 5'h00;
    end else if (i_clk_en) begin
      state_ff <= nxt_state;
      phase_ff <= nxt_phase;
    end
  end

  // Timing fields captured once so register writes cannot bend a conversion
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      conv_sel_ff <= `ACS_CONV_SEL_24;
      samp_sel_ff <= 2'h0;
      tcc_len_ff  <= `ACS_TCC_LEN_24;
    end else if (i_clk_en && (state_ff == st_idle) && i_start) begin
      conv_sel_ff <= i_converter_control_reg_hi[`ACS_CONV_SEL_MSB:`ACS_CONV_SEL_LSB];
      samp_sel_ff <= i_converter_control_reg_hi[`ACS_SAMP_SEL_MSB:`ACS_SAMP_SEL_LSB];
      tcc_len_ff  <= tmr.len;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Comparator synchroniser; only the second stage is used
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cmp_meta_ff <= 1'b0;
      cmp_sync_ff <= 1'b0;
    end else if (i_clk_en) begin
      cmp_meta_ff <= i_cmp_above;
      cmp_sync_ff <= cmp_meta_ff;
    end
  end

  // Literal cannot be bit-selected, so the first trial word gets a name
  localparam logic [9:0] trial_init = `ACS_TRIAL_INIT;

  // Per bit: keep or drop the tested bit, then try the next lower one
  for (genvar b = 0; b < 10; b++) begin : g_sar
    assign nxt_trial[b] = enter_conv ? trial_init[b] :
                          (decide && bit_idx == 4'(b))         ? cmp_sync_ff :
                          (decide && bit_idx == 4'(b + 1))     ? 1'b1 :
                          trial_ff[b];
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      trial_ff <= 10'h000;
    end else if (i_clk_en) begin
      trial_ff <= nxt_trial;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output flops
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy_ff       <= 1'b0;
      sampling_ff   <= 1'b0;
      equalizing_ff <= 1'b0;
      loading_ff    <= 1'b0;
      strobe_ff     <= 1'b0;
      bit_index_ff  <= 4'h0;
      result_ff     <= 10'h000;
      done_ff       <= 1'b0;
    end else if (i_clk_en) begin
      busy_ff       <= (nxt_state != st_idle);
      sampling_ff   <= (nxt_state == st_sample);
      equalizing_ff <= (nxt_state == st_convert) && (nxt_phase >= `ACS_DECISION_STEPS);
      loading_ff    <= (nxt_state == st_load);
      strobe_ff     <= decide;
      bit_index_ff  <= decide ? bit_idx : bit_index_ff;
      done_ff       <= finish;
      if (finish) begin
        result_ff <= trial_ff;
      end
    end
  end

  assign o_busy           = busy_ff;
  assign o_sampling       = sampling_ff;
  assign o_equalizing     = equalizing_ff;
  assign o_result_loading = loading_ff;
  assign o_step_strobe    = strobe_ff;
  assign o_bit_index      = bit_index_ff;
  assign o_trial          = trial_ff;
  assign o_result         = result_ff;
  assign o_done           = done_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checking helpers: enabled-cycle counts per conversion
  logic [11:0] busy_cyc_ff, samp_cyc_ff, exp_total;
  logic [3:0]  strobe_cnt_ff, load_cyc_ff;
  logic [11:0] tcc12;
  assign tcc12     = 12'(tcc_len_ff);
  assign exp_total = 12'(14 * tcc12) + 12'((tcc12 << samp_sel_ff) << 1) + 12'h004;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy_cyc_ff   <= 12'h000;
      samp_cyc_ff   <= 12'h000;
      strobe_cnt_ff <= 4'h0;
      load_cyc_ff   <= 4'h0;
    end else if (i_clk_en) begin
      if (state_ff == st_idle) begin
        busy_cyc_ff   <= 12'h000;
        samp_cyc_ff   <= 12'h000;
        strobe_cnt_ff <= 4'h0;
        load_cyc_ff   <= 4'h0;
      end else begin
        busy_cyc_ff   <= busy_cyc_ff + 12'h001;
        samp_cyc_ff   <= samp_cyc_ff + {11'h000, state_ff == st_sample};
        strobe_cnt_ff <= strobe_cnt_ff + {3'h0, decide};
        load_cyc_ff   <= load_cyc_ff + {3'h0, state_ff == st_load};
      end
    end
  end

  a_sample_first: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    $rose(busy_ff) |-> sampling_ff && strobe_cnt_ff == 4'h0)
    else $error("conversion did not open with sampling");
  a_ten_decisions: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    $rose(done_ff) |-> strobe_cnt_ff == 4'hA)
    else $error("decision step count is not ten");
  a_fourteen_steps: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    $rose(done_ff) |-> busy_cyc_ff - samp_cyc_ff - 12'(load_cyc_ff) == 12'(14 * tcc12))
    else $error("conversion phase is not fourteen clocks");
  a_field_select: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_clk_en && state_ff == st_idle && i_start |=>
      samp_sel_ff == $past(i_converter_control_reg_hi[1:0]))
    else $error("sample select not taken from control field");
  a_tcc_decode: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    busy_ff |-> (conv_sel_ff == 2'h2) ? tcc_len_ff == 7'h60 :
                (conv_sel_ff == 2'h3) ? tcc_len_ff == 7'h30 : tcc_len_ff == 7'h18)
    else $error("conversion clock length wrong for select");
  a_sample_length: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_clk_en && enter_conv |=> samp_cyc_ff == 12'((tcc12 << samp_sel_ff) << 1))
    else $error("sample phase length wrong");
  a_total_time: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    $rose(done_ff) |-> busy_cyc_ff == exp_total && load_cyc_ff == 4'h4)
    else $error("total conversion time wrong");
  a_fields_held: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    busy_ff && $past(busy_ff) |-> $stable(tcc_len_ff) && $stable(samp_sel_ff))
    else $error("timing fields changed mid conversion");

  c_done_fast: cover property (@(posedge i_clock) disable iff (!i_rst_n)
    $rose(done_ff) && conv_sel_ff == 2'h0 && samp_sel_ff == 2'h0);
  c_done_slow: cover property (@(posedge i_clock) disable iff (!i_rst_n)
    $rose(done_ff) && conv_sel_ff == 2'h2 && samp_sel_ff == 2'h3);
  c_restart: cover property (@(posedge i_clock) disable iff (!i_rst_n)
    done_ff && i_clk_en && i_start ##1 sampling_ff);

endmodule : acs_sequencer
`default_nettype wire

// >>> acs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb import acs_pkg::*;;
  ////////////////////////////////////////////////////////////////////////////////
  // Stimulus and observed signals
  logic       i_clock = 1'b0;
  logic       i_rst_n = 1'b0;
  logic       i_clk_en = 1'b1;
  logic       i_start = 1'b0;
  logic [3:0] i_converter_control_reg_hi = 4'h0;
  logic       i_cmp_above = 1'b0;
  logic       o_busy, o_sampling, o_equalizing, o_result_loading, o_step_strobe, o_done;
  logic [3:0] o_bit_index;
  logic [9:0] o_trial, o_result;
  int         miscompares = 0;
  int         n_tests = 0;
  int         cyc = 0;

  // 20 MHz clock, one rising edge per CPU half-period
  always #25 i_clock = ~i_clock;

  acs_sequencer dut (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_clk_en(i_clk_en), .i_start(i_start),
    .i_converter_control_reg_hi(i_converter_control_reg_hi), .i_cmp_above(i_cmp_above),
    .o_busy(o_busy), .o_sampling(o_sampling), .o_equalizing(o_equalizing),
    .o_result_loading(o_result_loading), .o_step_strobe(o_step_strobe),
    .o_bit_index(o_bit_index), .o_trial(o_trial), .o_result(o_result), .o_done(o_done)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict, reached from the main sequence or the hang guard
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out

  // Whole run is about 20k cycles; a hang must not run forever
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      miscompares++;
      close_out();
    end
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (exp !== got) begin
      $display("FAIL %s expected %0h seen %0h", what, exp, got);
      miscompares++;
    end
  endtask : check

  // Conversion clock length; reserved code runs as the shortest one
  function automatic int tcc(input logic [1:0] c);
    case (c)
      2'h2: return 96;
      2'h3: return 48;
      default: return 24;
    endcase
  endfunction : tcc

  ////////////////////////////////////////////////////////////////////////////////
  // One conversion, measured phase by phase in enabled edges
  task automatic run_conv(input logic [3:0] sel, input logic cmp, input int frz_at,
                          input logic [3:0] late_sel, input logic hold);
    int   k, n_samp, n_eq, n_load, n_stb, cc, sc;
    logic order_bad;
    logic [31:0] exp_trial;
    cc = tcc(sel[3:2]);
    sc = cc << sel[1:0];
    k = 0; n_samp = 0; n_eq = 0; n_load = 0; n_stb = 0; order_bad = 1'b0;
    i_converter_control_reg_hi = sel;
    i_cmp_above = cmp;
    i_start = 1'b1;
    @(negedge i_clock);
    i_start = hold;
    // Sampling is already up after the taking edge
    if (o_sampling === 1'b1) n_samp++;
    while (k < 3000) begin
      @(negedge i_clock);
      k++;
      if (k == 3) i_converter_control_reg_hi = late_sel;
      if (o_sampling === 1'b1) n_samp++;
      if (o_equalizing === 1'b1) n_eq++;
      if (o_result_loading === 1'b1) n_load++;
      if (o_step_strobe === 1'b1) begin
        // Decided bits follow the comparator, the next lower bit is on trial
        if (n_stb < 10) begin
          exp_trial = (cmp ? (32'h3FF << (9 - n_stb)) & 32'h3FF : 32'h0) |
                      ((n_stb < 9) ? 32'h1 << (8 - n_stb) : 32'h0);
          check("bit index", 9 - n_stb, {28'h0, o_bit_index});
          check("trial word", exp_trial, {22'h0, o_trial});
        end
        n_stb++;
      end
      if (o_sampling === 1'b1 && n_stb != 0) order_bad = 1'b1;
      if (o_done === 1'b1) break;
      // Frozen edges must not count toward any duration
      if (k == frz_at) begin
        i_clk_en = 1'b0;
        repeat (7) @(negedge i_clock);
        check("frozen sampling", 1, o_sampling);
        i_clk_en = 1'b1;
      end
    end
    check("total length", 14 * cc + 2 * sc + 4, k);
    check("sample length", 2 * sc, n_samp);
    check("sample first", 0, order_bad);
    check("decision steps", 10, n_stb);
    check("equalize length", 4 * cc, n_eq);
    check("load length", 4, n_load);
    check("result", cmp ? 32'h3FF : 32'h0, {22'h0, o_result});
    check("busy at done", 0, o_busy);
  endtask : run_conv

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_all_codes();
    logic [1:0] cs [3] = '{2'h0, 2'h2, 2'h3};
    for (int c = 0; c < 3; c++) begin
      for (int s = 0; s < 4; s++) begin
        run_conv({cs[c], 2'(s)}, 1'(s), 0, {cs[c], 2'(s)}, 1'b0);
      end
    end
    $display("test all_codes done");
  endtask : t_all_codes

  task automatic t_reserved();
    run_conv(4'h5, 1'b1, 0, 4'h5, 1'b0);
    $display("test reserved done");
  endtask : t_reserved

  // A rewrite in mid-conversion must not stretch or shorten it
  task automatic t_hold_fields();
    run_conv(4'h0, 1'b0, 0, 4'hF, 1'b0);
    run_conv(4'hB, 1'b1, 0, 4'h0, 1'b0);
    $display("test hold_fields done");
  endtask : t_hold_fields

  task automatic t_freeze();
    run_conv(4'hC, 1'b1, 5, 4'hC, 1'b0);
    $display("test freeze done");
  endtask : t_freeze

  // Start held high restarts one edge after done; reset then clears everything
  task automatic t_back_to_back();
    run_conv(4'h0, 1'b1, 0, 4'h0, 1'b1);
    @(negedge i_clock);
    check("restart busy", 1, o_busy);
    check("restart sampling", 1, o_sampling);
    i_start = 1'b0;
    i_rst_n = 1'b0;
    #1;
    check("reset busy", 0, o_busy);
    check("reset result", 0, {22'h0, o_result});
    repeat (3) @(negedge i_clock);
    i_rst_n = 1'b1;
    @(negedge i_clock);
    check("idle after reset", 0, o_busy);
    $display("test back_to_back done");
  endtask : t_back_to_back

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (3) @(negedge i_clock);
    i_rst_n = 1'b1;
    t_all_codes();
    t_reserved();
    t_hold_fields();
    t_freeze();
    t_back_to_back();
    close_out();
  end
endmodule : tb
`default_nettype wire
